/* File: acsp_bus_if.sv */
// Three-wire serial bus between host and device; resolves the open-drain data line.
// Assumes an external pull-up: the line is low whenever either side enables its driver.
`timescale 1ns/1ps
interface acsp_bus_if;
  logic busClk;
  logic frameSelect;
  logic hostDataOe;
  logic devDataOe;
  logic dataLine;
  assign dataLine = ~(hostDataOe | devDataOe);
  modport host (output busClk, output frameSelect, output hostDataOe, input dataLine);
  modport device (input busClk, input frameSelect, output devDataOe, input dataLine);
endinterface : acsp_bus_if

/* File: acsp_bus_sva.sv */
// Checker for the three-wire bus joining the host and device ends.
// Assumes every bus signal is sampled by core_clk, so bus edges are seen a cycle late.
`timescale 1ns/1ps
module acsp_bus_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic busClk,
  input wire logic frameSelect,
  input wire logic hostDataOe,
  input wire logic devDataOe,
  input wire logic dataLine
);
  logic clkQ;
  logic rise;
  logic [3:0] addrN_q;
  logic [3:0] valN_q;
  logic [5:0] gap_q;
  logic [7:0] addr_q;
  assign rise = busClk & ~clkQ;
  // Gap saturates so the first edge after reset is never judged too early
  always_ff @(posedge core_clk) begin
    clkQ <= busClk;
    if (!rst_n) begin
      addrN_q <= 4'h0;
      valN_q <= 4'h0;
      gap_q <= 6'h3F;
      addr_q <= 8'h00;
    end else begin
      gap_q <= (busClk != clkQ) ? 6'h00 : ((gap_q == 6'h3F) ? gap_q : gap_q + 6'h01);
      addrN_q <= frameSelect ? 4'h0 : addrN_q + {3'h0, rise};
      valN_q <= frameSelect ? valN_q + {3'h0, rise} : 4'h0;
      if (!frameSelect && rise) begin
        addr_q <= {addr_q[6:0], dataLine};
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_bit_stable: assert property (rise |-> $stable({hostDataOe, devDataOe}))
    else $error("data changed at bus clock rise");
  a_clk_rate: assert property ((busClk != clkQ) |-> gap_q >= 6'h0F)
    else $error("bus clock half period too short");
  a_addr_eight: assert property ($rose(frameSelect) |-> addrN_q == 4'h8 || addrN_q == 4'h0)
    else $error("address byte not eight bits");
  a_value_eight: assert property ($fell(frameSelect) |-> valN_q == 4'h8 || valN_q == 4'h0)
    else $error("value byte not eight bits");
  a_clk_parked: assert property ($rose(frameSelect) |-> busClk)
    else $error("select rose with bus clock low");
  a_end_pulse: assert property ($fell(frameSelect) && valN_q == 4'h8 |-> (!frameSelect && busClk) [*8] ##30 !frameSelect)
    else $error("end pulse too short");
  a_dev_quiet_addr: assert property (!frameSelect && addrN_q != 4'h0 |-> !devDataOe)
    else $error("device drove data during address");
  a_dev_read_only: assert property (devDataOe |-> frameSelect && addr_q == 8'h47)
    else $error("device drove data outside a read");
  a_host_release: assert property (frameSelect && valN_q != 4'h0 && addr_q == 8'h47 |-> !hostDataOe)
    else $error("host drove data during read reply");
endmodule : acsp_bus_sva

/* File: acsp_consts.svh */
// Constants for the three-wire serial control port: addresses, field widths, reset values, timing.
// Included by the package and both ends; definitions only.
`ifndef ACSP_CONSTS_SVH
`define ACSP_CONSTS_SVH

`define ACSP_ADDR_BASE 5'h08
`define ACSP_FN_INPUT 3'h0
`define ACSP_FN_LOUD 3'h1
`define ACSP_FN_BASS 3'h2
`define ACSP_FN_TREBLE 3'h3
`define ACSP_FN_VOL_L 3'h4
`define ACSP_FN_VOL_R 3'h5
`define ACSP_FN_MODE 3'h6
`define ACSP_FN_READ 3'h7
`define ACSP_FRAME_BITS 5'h10
`define ACSP_BYTE_BITS 4'h8
`define ACSP_RST_INPUT 2'h3
`define ACSP_RST_TONE 4'h6
`define ACSP_RST_VOL 6'h28
`define ACSP_VOL_MAX 6'h28
`define ACSP_TONE_MAX 4'h9
`define ACSP_RST_MODE 3'h5
`define ACSP_CLK_HZ 40000000
`define ACSP_BUS_HZ 1000000
`define ACSP_HALF_CYC ((`ACSP_CLK_HZ + 2 * `ACSP_BUS_HZ - 1) / (2 * `ACSP_BUS_HZ))
`define ACSP_END_PULSE_NS 1000
`define ACSP_END_CYC ((`ACSP_END_PULSE_NS * 40 + 999) / 1000)

`endif

/* File: acsp_device.sv */
// Device end: receives 16-bit frames, latches function settings, answers flag reads.
// Assumes core_clk at 40 MHz, far faster than the bus clock; all bus pins are synchronised.
// Summary of operation
// - Data stable and sampled on rising clock
// - Address shifted while select low, 40h-47h
// - Sixteen bits: address byte, then value
// - Last eight bits are function value
// - Host bus clock at most 1 MHz
// - Host drives data only open-drain
// - End of frame latches shift register
// - Reset: volume min, tone flat, muted
// - Two pulled-up active-low flags readable
// - Input select: three sources or mute
// - Mode: stereo, left-only or right-only
// - Independent left and right volume
// - Input codes 00,01,10 inputs; 11 mute
// - Volume six bits, 2 dB, clamp 80
// - Tone four bits, 0110 flat, clamp
// - Read reply: flag one bit0, two bit1
`timescale 1ns/1ps
`include "acsp_consts.svh"
module acsp_device (
  input wire logic core_clk,
  input wire logic rst_n,
  acsp_bus_if.device bus,
  input wire logic flagOneN,
  input wire logic flagTwoN,
  output logic [1:0] inputSel,
  output logic muted,
  output logic loudnessOn,
  output logic [3:0] bassCode,
  output logic [3:0] trebleCode,
  output logic [5:0] volLeft,
  output logic [5:0] volRight,
  output acsp_pkg::acsp_mode_t outMode
);
  // Synchronisers: stage one feeds only stage two
  logic [3:0] s1_q, s2_q;
  logic clkOld_q, fsOld_q;
  always_ff @(posedge core_clk) begin
    s1_q <= {bus.busClk, bus.frameSelect, bus.dataLine, flagOneN & flagTwoN};
    s2_q <= s1_q;
  end
  logic [1:0] f1_q, f2_q;
  always_ff @(posedge core_clk) begin
    f1_q <= {flagTwoN, flagOneN};
    f2_q <= f1_q;
  end
  wire logic clkS = s2_q[3];
  wire logic fsS = s2_q[2];
  wire logic datS = s2_q[1];
  wire logic rise = clkS & ~clkOld_q;
  wire logic fall = ~clkS & clkOld_q;
  wire logic fsRise = fsS & ~fsOld_q;

  function automatic logic [5:0] volClamp(input logic [5:0] c);
    volClamp = (c > `ACSP_VOL_MAX) ? `ACSP_VOL_MAX : c;
  endfunction : volClamp
  function automatic logic [3:0] toneClamp(input logic [3:0] c);
    toneClamp = (c > `ACSP_TONE_MAX) ? `ACSP_TONE_MAX : c;
  endfunction : toneClamp

  logic [7:0] addr_q, addr_d, val_q, val_d;
  logic [3:0] nVal_q, nVal_d;
  logic dataSeen_q, dataSeen_d;
  logic [1:0] flagLatch_q, flagLatch_d;
  logic [7:0] rdSh_q, rdSh_d;
  logic oe_q, oe_d;
  logic [1:0] in_q, in_d;
  logic loud_q, loud_d;
  logic mute_q, mute_d;
  logic [3:0] bass_q, bass_d, treb_q, treb_d;
  logic [5:0] vl_q, vl_d, vr_q, vr_d;
  acsp_pkg::acsp_mode_t mode_q, mode_d;
  wire logic addrHit = (addr_q[7:3] == `ACSP_ADDR_BASE);
  wire logic isRead = addrHit && (addr_q[2:0] == `ACSP_FN_READ);

  always_comb begin
    addr_d = addr_q;
    val_d = val_q;
    nVal_d = nVal_q;
    dataSeen_d = dataSeen_q;
    flagLatch_d = flagLatch_q;
    rdSh_d = rdSh_q;
    oe_d = oe_q;
    in_d = in_q;
    loud_d = loud_q;
    bass_d = bass_q;
    treb_d = treb_q;
    vl_d = vl_q;
    vr_d = vr_q;
    mode_d = mode_q;
    if (rise) begin
      if (!fsS) begin
        addr_d = {addr_q[6:0], datS};
        nVal_d = 4'h0;
        dataSeen_d = 1'b0;
      end else begin
        val_d = {val_q[6:0], datS};
        if (nVal_q != `ACSP_BYTE_BITS) begin
          nVal_d = nVal_q + 4'h1;
        end
        if (!dataSeen_q) begin
          flagLatch_d = ~f2_q;
          rdSh_d = {6'h00, ~f2_q[1], ~f2_q[0]};
        end
        dataSeen_d = 1'b1;
      end
    end
    // Reply bits change on the falling edge so they are stable at the host's rise
    if (fall && fsS && isRead) begin
      oe_d = dataSeen_q ? rdSh_q[6] : rdSh_q[7];
      if (dataSeen_q) begin
        rdSh_d = {rdSh_q[6:0], 1'b0};
      end
    end
    if (fall && fsS && isRead && !dataSeen_q) begin
      oe_d = 1'b0;
    end
    // Release after the last value rise so the line is free before the end pulse
    if (rise && fsS && isRead && (!dataSeen_q || nVal_q == `ACSP_BYTE_BITS - 4'h1)) begin
      oe_d = 1'b0;
    end
    if (!fsS) begin
      oe_d = 1'b0;
    end
    // Latch on the end pulse only after a full value byte arrived
    if (!fsS && fsOld_q && dataSeen_q && nVal_q == `ACSP_BYTE_BITS && addrHit) begin
      case (addr_q[2:0])
        `ACSP_FN_INPUT: in_d = val_q[1:0];
        `ACSP_FN_LOUD: loud_d = val_q[0];
        `ACSP_FN_BASS: bass_d = toneClamp(val_q[3:0]);
        `ACSP_FN_TREBLE: treb_d = toneClamp(val_q[3:0]);
        `ACSP_FN_VOL_L: vl_d = volClamp(val_q[5:0]);
        `ACSP_FN_VOL_R: vr_d = volClamp(val_q[5:0]);
        `ACSP_FN_MODE: begin
          if (val_q[2:1] == 2'h3) mode_d = acsp_pkg::ACSP_RIGHT_MONO;
          else if (val_q[2:0] == 3'h4) mode_d = acsp_pkg::ACSP_LEFT_MONO;
          else if (val_q[2:0] == `ACSP_RST_MODE) mode_d = acsp_pkg::ACSP_STEREO;
        end
        default: ;
      endcase
    end
    // Every select fall closes the frame so a later fall cannot latch stale data
    if (!fsS && fsOld_q) begin
      nVal_d = 4'h0;
      dataSeen_d = 1'b0;
    end
    mute_d = (in_d == 2'h3);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clkOld_q <= 1'b1;
      fsOld_q <= 1'b1;
      addr_q <= 8'h00;
      val_q <= 8'h00;
      nVal_q <= 4'h0;
      dataSeen_q <= 1'b0;
      flagLatch_q <= 2'h0;
      rdSh_q <= 8'h00;
      oe_q <= 1'b0;
      in_q <= `ACSP_RST_INPUT;
      loud_q <= 1'b0;
      mute_q <= 1'b1;
      bass_q <= `ACSP_RST_TONE;
      treb_q <= `ACSP_RST_TONE;
      vl_q <= `ACSP_RST_VOL;
      vr_q <= `ACSP_RST_VOL;
      mode_q <= acsp_pkg::ACSP_STEREO;
    end else begin
      clkOld_q <= clkS;
      fsOld_q <= fsS;
      addr_q <= addr_d;
      val_q <= val_d;
      nVal_q <= nVal_d;
      dataSeen_q <= dataSeen_d;
      flagLatch_q <= flagLatch_d;
      rdSh_q <= rdSh_d;
      oe_q <= oe_d;
      in_q <= in_d;
      loud_q <= loud_d;
      mute_q <= mute_d;
      bass_q <= bass_d;
      treb_q <= treb_d;
      vl_q <= vl_d;
      vr_q <= vr_d;
      mode_q <= mode_d;
    end
  end
  assign bus.devDataOe = oe_q;
  assign inputSel = in_q;
  assign muted = mute_q;
  assign loudnessOn = loud_q;
  assign bassCode = bass_q;
  assign trebleCode = treb_q;
  assign volLeft = vl_q;
  assign volRight = vr_q;
  assign outMode = mode_q;
endmodule : acsp_device

/* File: acsp_host.sv */
// Host end: sends one 16-bit frame per request, reads back the flag byte on reads.
// Assumes core_clk at 40 MHz; bus clock derived here at no more than 1 MHz.
`timescale 1ns/1ps
`include "acsp_consts.svh"
module acsp_host (
  input wire logic core_clk,
  input wire logic rst_n,
  acsp_bus_if.host bus,
  input wire logic reqValid,
  input wire logic [2:0] reqFunc,
  input wire logic [7:0] reqValue,
  output logic reqReady,
  output logic rdValid,
  output logic [7:0] rdValue
);
  localparam logic [5:0] HALF = 6'(`ACSP_HALF_CYC);
  localparam logic [5:0] ENDC = 6'(`ACSP_END_CYC);
  acsp_pkg::acsp_hstate_t state_q, state_d;
  logic [5:0] div_q, div_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, val_q, val_d;
  logic clk_q, clk_d, fs_q, fs_d, oe_q, oe_d, rdv_q, rdv_d, isRd_q, isRd_d;
  logic [7:0] rd_q, rd_d;
  logic rdy_q, rdy_d;
  logic d1_q, d2_q;
  always_ff @(posedge core_clk) begin
    d1_q <= bus.dataLine;
    d2_q <= d1_q;
  end
  always_comb begin
    state_d = state_q;
    div_d = div_q;
    bit_d = bit_q;
    sh_d = sh_q;
    val_d = val_q;
    clk_d = clk_q;
    fs_d = fs_q;
    oe_d = oe_q;
    rdv_d = 1'b0;
    isRd_d = isRd_q;
    rd_d = rd_q;
    case (state_q)
      acsp_pkg::ACSP_H_IDLE: begin
        clk_d = 1'b1;
        fs_d = 1'b1;
        oe_d = 1'b0;
        div_d = 6'h00;
        if (reqValid) begin
          sh_d = {`ACSP_ADDR_BASE, reqFunc};
          val_d = reqValue;
          isRd_d = (reqFunc == `ACSP_FN_READ);
          bit_d = 4'h0;
          fs_d = 1'b0;
          clk_d = 1'b0;
          oe_d = ~sh_d[7];
          state_d = acsp_pkg::ACSP_H_ADDR;
        end
      end
      acsp_pkg::ACSP_H_ADDR, acsp_pkg::ACSP_H_DATA: begin
        div_d = div_q + 6'h01;
        if (div_q == HALF - 6'h01) begin
          div_d = 6'h00;
          clk_d = ~clk_q;
          if (!clk_q) begin
            // Rising edge: device samples; host captures read data here too
            if (state_q == acsp_pkg::ACSP_H_DATA) begin
              // Line low means flag asserted; store asserted as 1
              rd_d = {rd_q[6:0], ~d2_q};
            end
          end else begin
            // Falling edge: advance to the next bit, data stays stable over the rise
            sh_d = {sh_q[6:0], 1'b0};
            bit_d = bit_q + 4'h1;
            if (bit_q == `ACSP_BYTE_BITS - 4'h1) begin
              clk_d = 1'b1;
              oe_d = 1'b0;
              bit_d = 4'h0;
              if (state_q == acsp_pkg::ACSP_H_ADDR) begin
                fs_d = 1'b1;
                sh_d = val_q;
                state_d = acsp_pkg::ACSP_H_GAP;
              end else begin
                state_d = acsp_pkg::ACSP_H_END;
              end
            end else begin
              oe_d = ~sh_q[6] & ~(isRd_q && state_q == acsp_pkg::ACSP_H_DATA);
            end
          end
        end
      end
      acsp_pkg::ACSP_H_GAP: begin
        div_d = div_q + 6'h01;
        if (div_q == HALF - 6'h01) begin
          div_d = 6'h00;
          clk_d = 1'b0;
          oe_d = ~sh_q[7] & ~isRd_q;
          state_d = acsp_pkg::ACSP_H_DATA;
        end
      end
      acsp_pkg::ACSP_H_END: begin
        // Frame ends with a low pulse on frame select of at least 1 us
        div_d = div_q + 6'h01;
        if (div_q == HALF - 6'h01) begin
          fs_d = 1'b0;
        end
        if (div_q == HALF + ENDC) begin
          fs_d = 1'b1;
          rdv_d = isRd_q;
          state_d = acsp_pkg::ACSP_H_IDLE;
        end
      end
      default: state_d = acsp_pkg::ACSP_H_IDLE;
    endcase
    rdy_d = (state_d == acsp_pkg::ACSP_H_IDLE);
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= acsp_pkg::ACSP_H_IDLE;
      div_q <= 6'h00;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      val_q <= 8'h00;
      clk_q <= 1'b1;
      fs_q <= 1'b1;
      oe_q <= 1'b0;
      rdv_q <= 1'b0;
      isRd_q <= 1'b0;
      rd_q <= 8'h00;
      rdy_q <= 1'b1;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      val_q <= val_d;
      clk_q <= clk_d;
      fs_q <= fs_d;
      oe_q <= oe_d;
      rdv_q <= rdv_d;
      isRd_q <= isRd_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
    end
  end
  assign bus.busClk = clk_q;
  assign bus.frameSelect = fs_q;
  assign bus.hostDataOe = oe_q;
  assign reqReady = rdy_q;
  assign rdValid = rdv_q;
  assign rdValue = rd_q;
endmodule : acsp_host

/* File: acsp_pkg.sv */
// Types for the two ends of the serial control port: device output mode, host state codes.
// Assumes acsp_consts.svh is on the include path.
`include "acsp_consts.svh"
package acsp_pkg;
  typedef enum logic [3:0] {
    ACSP_STEREO = 4'h1,
    ACSP_LEFT_MONO = 4'h2,
    ACSP_RIGHT_MONO = 4'h4,
    ACSP_MODE_NONE = 4'h8
  } acsp_mode_t;
  typedef enum logic [4:0] {
    ACSP_H_IDLE = 5'h01,
    ACSP_H_ADDR = 5'h02,
    ACSP_H_GAP = 5'h04,
    ACSP_H_DATA = 5'h08,
    ACSP_H_END = 5'h10
  } acsp_hstate_t;
endpackage : acsp_pkg

/* File: audio_control_serial_port_bench.sv */
// Bench joining host and device ends on one bus; drives host requests and device flags.
// Assumes the host only emits valid addresses, so foreign-address frames are not exercised.
`timescale 1ns/1ps
`include "acsp_consts.svh"
module audio_control_serial_port_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  logic [2:0] reqFunc = 3'h0;
  logic [7:0] reqValue = 8'h00;
  logic reqReady;
  logic rdValid;
  logic [7:0] rdValue;
  logic flagOneN = 1'b1;
  logic flagTwoN = 1'b1;
  logic [1:0] inputSel;
  logic muted;
  logic loudnessOn;
  logic [3:0] bassCode;
  logic [3:0] trebleCode;
  logic [5:0] volLeft;
  logic [5:0] volRight;
  acsp_pkg::acsp_mode_t outMode;
  logic [1:0] eIn = 2'h3;
  logic eLoud = 1'b0;
  logic [5:0] eBass = 6'h06;
  logic [5:0] eTreb = 6'h06;
  logic [5:0] eVolL = 6'h28;
  logic [5:0] eVolR = 6'h28;
  acsp_pkg::acsp_mode_t eMode = acsp_pkg::ACSP_STEREO;
  logic rdSeen = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  acsp_bus_if bus();
  acsp_host i_acsp_host(.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .reqValid(reqValid), .reqFunc(reqFunc),
    .reqValue(reqValue), .reqReady(reqReady), .rdValid(rdValid), .rdValue(rdValue));
  acsp_device i_acsp_device(.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .flagOneN(flagOneN),
    .flagTwoN(flagTwoN), .inputSel(inputSel), .muted(muted), .loudnessOn(loudnessOn), .bassCode(bassCode),
    .trebleCode(trebleCode), .volLeft(volLeft), .volRight(volRight), .outMode(outMode));
  acsp_bus_sva i_acsp_bus_sva(.core_clk(core_clk), .rst_n(rst_n), .busClk(bus.busClk),
    .frameSelect(bus.frameSelect), .hostDataOe(bus.hostDataOe), .devDataOe(bus.devDataOe),
    .dataLine(bus.dataLine));
  always #12.5 core_clk = ~core_clk;
  // rdValid stands one cycle only, so it is caught here
  always @(posedge core_clk) if (rdValid === 1'b1) rdSeen <= 1'b1;
  task automatic wrap_up();
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk_set(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: setting %h expected %h", $time, got, exp);
    end
  endtask : chk_set
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd
  function automatic logic [5:0] clampTo(input logic [5:0] v, input logic [5:0] top);
    return (v > top) ? top : v;
  endfunction : clampTo
  task automatic check_all();
    chk_set({6'h00, inputSel}, {6'h00, eIn});
    chk_set({7'h00, muted}, {7'h00, eIn == 2'h3});
    chk_set({7'h00, loudnessOn}, {7'h00, eLoud});
    chk_set({4'h0, bassCode}, {2'h0, eBass});
    chk_set({4'h0, trebleCode}, {2'h0, eTreb});
    chk_set({2'h0, volLeft}, {2'h0, eVolL});
    chk_set({2'h0, volRight}, {2'h0, eVolR});
    chk_set({4'h0, outMode}, {4'h0, eMode});
  endtask : check_all
  task automatic wait_ready();
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      $display("Error at %0t: host stuck busy", $time);
      wrap_up();
    end
  endtask : wait_ready
  task automatic wr(input logic [2:0] f, input logic [7:0] v);
    wait_ready();
    reqValid = 1'b1;
    reqFunc = f;
    reqValue = v;
    @(posedge core_clk);
    #2;
    reqValid = 1'b0;
    wait_ready();
    case (f)
      3'h0: eIn = v[1:0];
      3'h1: eLoud = v[0];
      3'h2: eBass = clampTo({2'h0, v[3:0]}, 6'h09);
      3'h3: eTreb = clampTo({2'h0, v[3:0]}, 6'h09);
      3'h4: eVolL = clampTo(v[5:0], 6'h28);
      3'h5: eVolR = clampTo(v[5:0], 6'h28);
      3'h6: if (v[2]) eMode = v[1] ? acsp_pkg::ACSP_RIGHT_MONO : (v[0] ? acsp_pkg::ACSP_STEREO : acsp_pkg::ACSP_LEFT_MONO);
      default: ;
    endcase
    check_all();
  endtask : wr
  task automatic t_words();
    logic [7:0] tv [7] = '{8'h00, 8'h03, 8'hF6, 8'h09, 8'h0C, 8'h0A, 8'h06};
    logic [7:0] vv [5] = '{8'hC0, 8'h14, 8'h28, 8'h3F, 8'hE9};
    logic [7:0] mv [6] = '{8'hFC, 8'h05, 8'h06, 8'h07, 8'h03, 8'h05};
    for (int i = 0; i < 4; i++) wr(`ACSP_FN_INPUT, {6'h2B, i[1:0]});
    wr(`ACSP_FN_LOUD, 8'hFF);
    wr(`ACSP_FN_LOUD, 8'h7E);
    for (int i = 0; i < 7; i++) begin
      wr(`ACSP_FN_BASS, tv[i]);
      wr(`ACSP_FN_TREBLE, tv[6 - i]);
    end
    for (int i = 0; i < 5; i++) begin
      wr(`ACSP_FN_VOL_L, vv[i]);
      wr(`ACSP_FN_VOL_R, vv[4 - i]);
    end
    for (int i = 0; i < 6; i++) wr(`ACSP_FN_MODE, mv[i]);
  endtask : t_words
  task automatic t_read();
    for (int i = 0; i < 4; i++) begin
      flagOneN = ~i[0];
      flagTwoN = ~i[1];
      rdSeen = 1'b0;
      wr(`ACSP_FN_READ, 8'hFF);
      // The one-cycle pulse is only caught at the following edge
      @(posedge core_clk);
      #2;
      chk_rd({6'h00, rdValue[1:0]}, {6'h00, i[1:0]});
      chk_rd({7'h00, rdSeen}, 8'h01);
    end
  endtask : t_read
  initial begin
    repeat (10) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #2;
    check_all();
    t_words();
    t_read();
    wrap_up();
  end
endmodule : audio_control_serial_port_bench
